// [rtl/pdsau_pkg.sv]
// Constants and types shared by the program and data space access unit
package pdsau_pkg;
  localparam int          PDSAU_DEA_W       = 16;
  localparam int          PDSAU_PA_W        = 24;
  localparam int          PDSAU_PW_W        = 24;
  localparam int          PDSAU_DW_W        = 16;
  localparam int          PDSAU_PAGE_W      = 8;
  localparam int          PDSAU_MAP_BIT     = 15;
  localparam int          PDSAU_CFG_BIT     = 7;
  localparam logic [15:0] PDSAU_ZERO_WORD   = 16'h0000;
  localparam logic [7:0]  PDSAU_ZERO_BYTE   = 8'h00;
  localparam logic [7:0]  PDSAU_PAGE_RST    = 8'h00;
  localparam logic [1:0]  PDSAU_STALL_ONE   = 2'h1;
  localparam logic [1:0]  PDSAU_STALL_TWO   = 2'h2;
  // Data RAM window; the X/Y split is wired in and not programmable
  localparam logic [15:0] PDSAU_RAM_BASE    = 16'h0800;
  localparam logic [15:0] PDSAU_RAM_END     = 16'h08ff;
  localparam logic [15:0] PDSAU_Y_BASE      = 16'h0880;
  // Register-port offsets, and the core control bit used here
  localparam logic [3:0]  PDSAU_REG_CORE    = 4'h0;
  localparam logic [3:0]  PDSAU_REG_VPAGE   = 4'h1;
  localparam logic [3:0]  PDSAU_REG_TPAGE   = 4'h2;
  localparam logic [3:0]  PDSAU_REG_STATUS  = 4'h3;
  localparam int          PDSAU_VIS_EN_BIT  = 2;

  typedef enum logic [2:0] {
    PDSAU_OP_NONE  = 3'h0,
    PDSAU_OP_DRD   = 3'h1,
    PDSAU_OP_DWR   = 3'h2,
    PDSAU_OP_MACRD = 3'h3,
    PDSAU_OP_TRDL  = 3'h4,
    PDSAU_OP_TRDH  = 3'h5,
    PDSAU_OP_TWRL  = 3'h6,
    PDSAU_OP_TWRH  = 3'h7
  } pdsau_op_t;

  typedef enum logic [1:0] {
    PDSAU_ST_IDLE  = 2'h0,
    PDSAU_ST_STALL = 2'h1,
    PDSAU_ST_DONE  = 2'h2
  } pdsau_state_t;
endpackage

// [rtl/pdsau_table_fmt.sv]
// Combinational formatter for table reads of a program word
`timescale 1ns/10ps
`default_nettype none
module pdsau_table_fmt
  import pdsau_pkg::*;
(
  input  wire logic [23:0] pword_in,
  input  wire logic        high_in,
  input  wire logic        byte_in,
  input  wire logic        bsel_in,
  output logic      [15:0] data_out
);
  always_comb begin
    data_out = PDSAU_ZERO_WORD;
    if (!high_in) begin
      if (!byte_in) begin
        data_out = pword_in[15:0]; // RL1
      end else begin
        data_out = {PDSAU_ZERO_BYTE, bsel_in ? pword_in[15:8] : pword_in[7:0]}; // RL2
      end
    end else begin
      if (!byte_in) begin
        data_out = {PDSAU_ZERO_BYTE, pword_in[23:16]}; // RL3
      end else begin
        data_out = {PDSAU_ZERO_BYTE, bsel_in ? PDSAU_ZERO_BYTE : pword_in[23:16]}; // RL4
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/pdsau_top.sv]
// Program and data space access unit of the core
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// RL1: Low table word read returns program bits 15..0 as data 15..0.
// RL2: Low table byte read returns bits 7..0 or 15..8 by byte select.
// RL3: High table word read returns bits 23..16 in low byte, upper byte zero.
// RL4: High table byte read returns bits 23..16 for select zero, else zero.
// RL5: Low table ops hit bits 15..0; only high ops reach the top byte.
// RL6: Program addresses step by two per 24-bit word.
// RL7: Map to program memory only if address bit 15 and visibility enable set.
// RL8: Mapped address is visibility page above the low 15 address bits.
// RL9: Mapped read returns only the low 16 bits of the program word.
// RL10: Mapping is suspended during any table read or write.
// RL11: Outside repeat, mapping costs one cycle for MAC/move, two otherwise.
// RL12: Inside repeat, two cycles on first, last, interrupt exit and re-entry.
// RL13: MAC reads use Y pointers for Y, X pointers for X, concurrently.
// RL14: MAC X reads exclude Y range; otherwise X spans all data memory.
// RL15: All writes go over the X write bus, never the Y bus.
// RL16: Bit reversal only on X writes; modulo addressing in X space.
// RL17: Y space serves only MAC prefetch; others reach Y through X.
// RL18: Accumulator write-back may land anywhere over the X bus.
// RL19: Unimplemented or wrong-space MAC reads return all zero.
// RL20: The X/Y boundary is fixed in hardware.
// RL21: Data addresses are 16-bit byte addresses over 64 Kbytes.
// RL22: User accesses stay low; table page bit 7 picks configuration space.
// RL23: Table writes only hand address and data to the flash unit.
module pdsau_top
  import pdsau_pkg::*;
#(
  parameter int RAM_WORDS = 128
)(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic        req_in,
  input  wire logic [2:0]  op_in,
  input  wire logic        byte_in,
  input  wire logic [15:0] x_ea_in,
  input  wire logic [15:0] y_ea_in,
  input  wire logic        x_ptr_is_x_in,
  input  wire logic        y_ptr_is_y_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        bitrev_in,
  input  wire logic [15:0] bitrev_base_in,
  input  wire logic        short_cost_in,
  input  wire logic        in_repeat_in,
  input  wire logic        rep_edge_in,
  input  wire logic [23:0] pmem_rdata_in,
  output logic      [23:0] pmem_addr_out,
  output logic             pmem_rd_out,
  output logic             flash_wr_out,
  output logic             flash_high_out,
  output logic      [15:0] flash_data_out,
  output logic             busy_out,
  output logic             done_out,
  output logic      [15:0] x_rdata_out,
  output logic      [15:0] y_rdata_out
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] core_control_reg_q;
  logic [7:0]  visibility_page_reg_q;
  logic [7:0]  table_page_reg_q;
  logic [15:0] ram_q [RAM_WORDS];
  pdsau_state_t state_q;
  logic [1:0]  stall_q;
  logic [15:0] map_reads_q;

  wire logic vis_en = core_control_reg_q[PDSAU_VIS_EN_BIT];

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      core_control_reg_q    <= PDSAU_ZERO_WORD;
      visibility_page_reg_q <= PDSAU_PAGE_RST;
      table_page_reg_q      <= PDSAU_PAGE_RST;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        PDSAU_REG_CORE:  core_control_reg_q <= reg_wdata_in;
        PDSAU_REG_VPAGE: visibility_page_reg_q <= reg_wdata_in[7:0];
        PDSAU_REG_TPAGE: table_page_reg_q <= reg_wdata_in[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= PDSAU_ZERO_WORD;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        PDSAU_REG_CORE:   reg_rdata_out <= core_control_reg_q;
        PDSAU_REG_VPAGE:  reg_rdata_out <= {PDSAU_ZERO_BYTE, visibility_page_reg_q};
        PDSAU_REG_TPAGE:  reg_rdata_out <= {PDSAU_ZERO_BYTE, table_page_reg_q};
        PDSAU_REG_STATUS: reg_rdata_out <= map_reads_q;
        default:          reg_rdata_out <= PDSAU_ZERO_WORD;
      endcase
    end else begin
      reg_rdata_out <= PDSAU_ZERO_WORD;
    end
  end

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  pdsau_op_t op;
  assign op = pdsau_op_t'(op_in);
  wire logic is_table = (op == PDSAU_OP_TRDL) || (op == PDSAU_OP_TRDH) ||
                        (op == PDSAU_OP_TWRL) || (op == PDSAU_OP_TWRH);
  wire logic is_data  = (op == PDSAU_OP_DRD) || (op == PDSAU_OP_DWR) || (op == PDSAU_OP_MACRD);
  // Table ops never map, even with bit 15 and enable set
  wire logic mapped = is_data && !is_table && x_ea_in[PDSAU_MAP_BIT] && vis_en; // RL7 RL10
  // Page above the low 15 bits; bit 0 stays a byte select, so words step by two
  wire logic [23:0] map_addr = {1'b0, visibility_page_reg_q, x_ea_in[14:0]}; // RL8 RL6
  wire logic [23:0] tbl_addr = {table_page_reg_q, x_ea_in[15:1], 1'b0}; // RL22 RL6

  // Cycle cost of a mapped access
  logic [1:0] cost;
  always_comb begin
    cost = PDSAU_STALL_TWO;
    if (!in_repeat_in) begin
      cost = short_cost_in ? PDSAU_STALL_ONE : PDSAU_STALL_TWO; // RL11
    end else begin
      cost = rep_edge_in ? PDSAU_STALL_TWO : PDSAU_STALL_ONE; // RL12
    end
  end

  // ----------------------------------------------------------------
  // Data RAM decode, fixed X/Y split
  // ----------------------------------------------------------------
  function automatic logic in_ram(input logic [15:0] a);
    in_ram = (a >= PDSAU_RAM_BASE) && (a <= PDSAU_RAM_END);
  endfunction
  function automatic logic in_y(input logic [15:0] a);
    in_y = (a >= PDSAU_Y_BASE) && (a <= PDSAU_RAM_END); // RL20
  endfunction

  localparam int IDX_W = $clog2(RAM_WORDS);
  // Bit reversal on the word index, relative to the buffer base
  logic [15:0] wr_ea;
  always_comb begin
    wr_ea = x_ea_in;
    if (bitrev_in) begin
      for (int i = 1; i < IDX_W + 1; i++) begin
        wr_ea[i] = x_ea_in[IDX_W + 1 - i] ^ bitrev_base_in[i]; // RL16
      end
    end
  end
  wire logic [15:0] x_off = x_ea_in - PDSAU_RAM_BASE;
  wire logic [15:0] y_off = y_ea_in - PDSAU_RAM_BASE;
  wire logic [15:0] w_off = wr_ea - PDSAU_RAM_BASE;
  wire logic [IDX_W-1:0] x_idx = x_off[IDX_W:1];
  wire logic [IDX_W-1:0] y_idx = y_off[IDX_W:1];
  wire logic [IDX_W-1:0] w_idx = w_off[IDX_W:1];

  // Write-back and ordinary writes share the one X write port; no Y write exists
  // A request that arrives while busy is dropped, so the write must be gated by the idle state too
  wire logic x_write = (state_q == PDSAU_ST_IDLE) && req_in && (op == PDSAU_OP_DWR) && !mapped &&
                       in_ram(wr_ea); // RL15 RL18
  always_ff @(posedge clk_in) begin
    if (x_write) begin
      if (!byte_in || !wr_ea[0]) begin
        if (!byte_in) begin
          ram_q[w_idx] <= wdata_in; // RL15
        end else begin
          ram_q[w_idx][7:0] <= wdata_in[7:0];
        end
      end else begin
        ram_q[w_idx][15:8] <= wdata_in[7:0];
      end
    end
  end

  // X read: MAC reads exclude Y range, others see the whole RAM
  logic [15:0] x_word;
  always_comb begin
    x_word = PDSAU_ZERO_WORD;
    if (op == PDSAU_OP_MACRD) begin
      if (x_ptr_is_x_in && in_ram(x_ea_in) && !in_y(x_ea_in)) begin
        x_word = ram_q[x_idx]; // RL13 RL14
      end
    end else if (in_ram(x_ea_in)) begin
      x_word = byte_in ? {PDSAU_ZERO_BYTE, x_ea_in[0] ? ram_q[x_idx][15:8] : ram_q[x_idx][7:0]}
                       : ram_q[x_idx]; // RL14 RL17 RL21
    end
  end
  // Y read path exists only for MAC prefetch
  wire logic [15:0] y_word = (op == PDSAU_OP_MACRD) && y_ptr_is_y_in && in_y(y_ea_in)
                             ? ram_q[y_idx] : PDSAU_ZERO_WORD; // RL17 RL19 RL13

  // ----------------------------------------------------------------
  // Table read formatting
  // ----------------------------------------------------------------
  logic [15:0] tbl_word;
  logic        hold_high_q;
  logic        hold_byte_q;
  logic        hold_bsel_q;
  logic        hold_map_q;
  pdsau_table_fmt u_fmt (
    .pword_in (pmem_rdata_in),
    .high_in  (hold_high_q),
    .byte_in  (hold_byte_q),
    .bsel_in  (hold_bsel_q),
    .data_out (tbl_word)
  );

  // ----------------------------------------------------------------
  // Sequencer: program memory answers from the held address while pmem_rd_out stands
  // ----------------------------------------------------------------
  wire logic start_idle = (state_q == PDSAU_ST_IDLE) && req_in;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q        <= PDSAU_ST_IDLE;
      stall_q        <= 2'h0;
      pmem_addr_out  <= 24'h000000;
      pmem_rd_out    <= 1'b0;
      flash_wr_out   <= 1'b0;
      flash_high_out <= 1'b0;
      flash_data_out <= PDSAU_ZERO_WORD;
      busy_out       <= 1'b0;
      done_out       <= 1'b0;
      x_rdata_out    <= PDSAU_ZERO_WORD;
      y_rdata_out    <= PDSAU_ZERO_WORD;
      hold_high_q    <= 1'b0;
      hold_byte_q    <= 1'b0;
      hold_bsel_q    <= 1'b0;
      hold_map_q     <= 1'b0;
    end else begin
      pmem_rd_out  <= 1'b0;
      flash_wr_out <= 1'b0;
      done_out     <= 1'b0;
      case (state_q)
        PDSAU_ST_IDLE: begin
          if (req_in) begin
            hold_high_q <= (op == PDSAU_OP_TRDH);
            hold_byte_q <= byte_in;
            hold_bsel_q <= x_ea_in[0];
            hold_map_q  <= mapped;
            if (op == PDSAU_OP_TWRL || op == PDSAU_OP_TWRH) begin
              pmem_addr_out  <= tbl_addr; // RL23
              flash_data_out <= wdata_in;
              flash_high_out <= (op == PDSAU_OP_TWRH); // RL5
              flash_wr_out   <= 1'b1;
              done_out       <= 1'b1;
            end else if (op == PDSAU_OP_TRDL || op == PDSAU_OP_TRDH) begin
              pmem_addr_out <= tbl_addr; // RL5
              pmem_rd_out   <= 1'b1;
              busy_out      <= 1'b1;
              stall_q       <= PDSAU_STALL_ONE;
              state_q       <= PDSAU_ST_STALL;
            end else if (mapped && op != PDSAU_OP_DWR) begin
              pmem_addr_out <= map_addr; // RL8
              pmem_rd_out   <= 1'b1;
              busy_out      <= 1'b1;
              stall_q       <= cost; // RL11 RL12
              state_q       <= PDSAU_ST_STALL;
            end else if (op != PDSAU_OP_NONE) begin
              x_rdata_out <= mapped ? PDSAU_ZERO_WORD : x_word; // RL19
              y_rdata_out <= y_word;
              done_out    <= 1'b1;
            end
          end
        end
        PDSAU_ST_STALL: begin
          if (stall_q == PDSAU_STALL_ONE) begin
            if (hold_map_q) begin
              x_rdata_out <= pmem_rdata_in[15:0]; // RL9
            end else begin
              x_rdata_out <= tbl_word;
            end
            y_rdata_out <= PDSAU_ZERO_WORD;
            busy_out    <= 1'b0;
            done_out    <= 1'b1;
            state_q     <= PDSAU_ST_IDLE;
          end else begin
            // Keep the read up until the word is taken; a released port is not valid
            pmem_rd_out <= 1'b1;
            stall_q     <= stall_q - 2'h1;
          end
        end
        default: state_q <= PDSAU_ST_IDLE;
      endcase
    end
  end

  // Count of mapped reads, readable as status
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      map_reads_q <= PDSAU_ZERO_WORD;
    end else if (start_idle && mapped && op != PDSAU_OP_DWR) begin
      map_reads_q <= map_reads_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  map_gate_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL7
    start_idle && (op == PDSAU_OP_DRD) && !(x_ea_in[15] && vis_en) |=> !pmem_rd_out)
    else $error("program read without mapping condition");
  table_nomap_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL10
    start_idle && (op == PDSAU_OP_TRDL) |=> pmem_addr_out[23:16] == $past(table_page_reg_q))
    else $error("table read used visibility page");
  map_addr_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL8
    start_idle && mapped && (op == PDSAU_OP_DRD) |=>
      pmem_addr_out == {1'b0, $past(visibility_page_reg_q), $past(x_ea_in[14:0])})
    else $error("mapped address wrong");
  cost_short_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL11
    start_idle && mapped && (op == PDSAU_OP_DRD) && !in_repeat_in && short_cost_in |=> ##1 done_out)
    else $error("one-cycle cost wrong");
  cost_long_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL12
    start_idle && mapped && (op == PDSAU_OP_DRD) && in_repeat_in && rep_edge_in |=> !done_out ##1 !done_out ##1 done_out)
    else $error("two-cycle cost wrong");
  map_low16_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL9
    state_q == PDSAU_ST_STALL && stall_q == PDSAU_STALL_ONE && hold_map_q |=> x_rdata_out == $past(pmem_rdata_in[15:0]))
    else $error("mapped data not low 16 bits");
  high_word_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL3
    state_q == PDSAU_ST_STALL && stall_q == PDSAU_STALL_ONE && !hold_map_q && hold_high_q |=> x_rdata_out[15:8] == 8'h00)
    else $error("high table read upper byte not zero");
  y_zero_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL19
    start_idle && (op == PDSAU_OP_MACRD) && !y_ptr_is_y_in |=> y_rdata_out == 16'h0000)
    else $error("wrong-space Y read not zero");
  flash_pass_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL23
    start_idle && (op == PDSAU_OP_TWRH) |=> flash_wr_out && flash_high_out && flash_data_out == $past(wdata_in))
    else $error("table write not handed over");
  low_word_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL1
    state_q == PDSAU_ST_STALL && stall_q == PDSAU_STALL_ONE && !hold_map_q && !hold_high_q && !hold_byte_q |=>
      x_rdata_out == $past(pmem_rdata_in[15:0]))
    else $error("low table word wrong");
  high_byte_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL4
    state_q == PDSAU_ST_STALL && stall_q == PDSAU_STALL_ONE && !hold_map_q && hold_high_q && hold_byte_q &&
      hold_bsel_q |=> x_rdata_out == 16'h0000)
    else $error("high table byte not zero");
  mac_dual_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL13
    start_idle && (op == PDSAU_OP_MACRD) && !mapped |=> done_out && !busy_out)
    else $error("dual read not in one cycle");
  rd_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL11
    busy_out |-> pmem_rd_out)
    else $error("program read dropped while busy");
endmodule
`default_nettype wire

// [test/pdsau_pmem_model.sv]
// Program memory model on the far side of the access unit
`timescale 1ns/10ps
`default_nettype none
module pdsau_pmem_model (
  input  wire logic        clk_in,
  input  wire logic        rd_in,
  input  wire logic [23:0] addr_in,
  output logic      [23:0] rdata_out
);
  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Word contents derive from the address so the bench can predict them
  logic [23:0] word;
  assign word = {addr_in[23:16] ^ 8'ha5, addr_in[15:0] ^ 16'h3c96};
  // Read off the held address; a released port shows the inverse so a stale sample fails
  always_comb begin
    rdata_out = (rd_in === 1'b1) ? word : ~word;
  end
endmodule
`default_nettype wire

// [test/pdsau_top_test.sv]
// Self-checking bench of the program and data space access unit
`timescale 1ns/10ps
`default_nettype none
module pdsau_top_test;
  import pdsau_pkg::*;
  logic        clk_in, rstn_in, reg_wr_in, reg_rd_in, req_in, byte_in, x_ptr_is_x_in, y_ptr_is_y_in;
  logic        bitrev_in, short_cost_in, in_repeat_in, rep_edge_in, pmem_rd_out, flash_wr_out;
  logic        flash_high_out, busy_out, done_out;
  logic [3:0]  reg_addr_in;
  logic [2:0]  op_in;
  logic [15:0] reg_wdata_in, reg_rdata_out, x_ea_in, y_ea_in, wdata_in, bitrev_base_in;
  logic [15:0] flash_data_out, x_rdata_out, y_rdata_out, d, a, wd;
  logic [23:0] pmem_rdata_in, pmem_addr_out, pa_seen, fl_seen, w, e;
  logic [15:0] ram [int];
  int          error_cnt, n_compared, n, cost, nmap;

  pdsau_top dut (.clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .req_in, .op_in, .byte_in, .x_ea_in, .y_ea_in, .x_ptr_is_x_in, .y_ptr_is_y_in, .wdata_in, .bitrev_in,
    .bitrev_base_in, .short_cost_in, .in_repeat_in, .rep_edge_in, .pmem_rdata_in, .pmem_addr_out,
    .pmem_rd_out, .flash_wr_out, .flash_high_out, .flash_data_out, .busy_out, .done_out, .x_rdata_out,
    .y_rdata_out);
  pdsau_pmem_model pmem (.clk_in, .rd_in(pmem_rd_out), .addr_in(pmem_addr_out), .rdata_out(pmem_rdata_in));

  // ----------------------------------------
  // Clock, monitors and tasks
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (pmem_rd_out === 1'b1) pa_seen <= pmem_addr_out;
    if (flash_wr_out === 1'b1) fl_seen <= {flash_high_out, 7'h00, flash_data_out};
  end
  function automatic logic [23:0] pw(input logic [23:0] ad);
    return {ad[23:16] ^ 8'ha5, ad[15:0] ^ 16'h3c96};
  endfunction
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] ad, input logic [15:0] dat);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= ad;
    reg_wdata_in <= dat;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] ad, output logic [15:0] dat);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= ad;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 dat = reg_rdata_out;
  endtask
  // Flags: x pointer, y pointer, bit reverse, short cost, in repeat, repeat edge
  task automatic acc(input pdsau_op_t op, input logic [15:0] xa, ya, wdat, input logic bt, input logic [5:0] f);
    @(posedge clk_in);
    req_in <= 1'b1;
    op_in <= op;
    x_ea_in <= xa;
    y_ea_in <= ya;
    wdata_in <= wdat;
    byte_in <= bt;
    {x_ptr_is_x_in, y_ptr_is_y_in, bitrev_in, short_cost_in, in_repeat_in, rep_edge_in} <= f;
    @(posedge clk_in);
    req_in <= 1'b0;
    n = 1;
    #1;
    while (done_out !== 1'b1 && n < 20) begin
      chk(24'(busy_out), 24'h1);
      @(posedge clk_in);
      #1 n++;
    end
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {rstn_in, reg_wr_in, reg_rd_in, req_in, byte_in, bitrev_in} = '0;
    {x_ptr_is_x_in, y_ptr_is_y_in, short_cost_in, in_repeat_in, rep_edge_in} = '0;
    {reg_addr_in, op_in, reg_wdata_in, x_ea_in, y_ea_in, wdata_in} = '0;
    bitrev_base_in = 16'h0002;
    error_cnt = 0;
    n_compared = 0;
    nmap = 0;
    void'($urandom(59));
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    reg_rd(PDSAU_REG_CORE, d);
    chk(d, 24'h0);
    reg_wr(PDSAU_REG_VPAGE, 16'h0037);
    reg_wr(PDSAU_REG_TPAGE, 16'h0085);
    reg_wr(4'hc, 16'hffff);
    reg_rd(4'hc, d);
    chk(d, 24'h0);
    reg_rd(PDSAU_REG_VPAGE, d);
    chk(d, 24'h0037);
    acc(PDSAU_OP_DRD, 16'h9234, 16'h0, 16'h0, 1'b0, 6'h30);
    chk(x_rdata_out, 24'h0);
    reg_wr(PDSAU_REG_CORE, 16'h0004);
    for (int i = 0; i < 10; i++) begin
      a = PDSAU_RAM_BASE + 16'(2 * $urandom_range(0, 127));
      wd = 16'($urandom());
      acc(PDSAU_OP_DWR, a, 16'h0, wd, 1'b0, 6'h30);
      chk(24'(n), 24'h1);
      ram[a] = wd;
    end
    acc(PDSAU_OP_DWR, 16'h0804, 16'h0, 16'h1357, 1'b0, 6'h38);
    ram[16'h0842] = 16'h1357;
    acc(PDSAU_OP_DWR, 16'h0810, 16'h0, 16'h2468, 1'b0, 6'h30);
    ram[16'h0810] = 16'h2468;
    acc(PDSAU_OP_DWR, 16'h0890, 16'h0, 16'hbeef, 1'b0, 6'h30);
    ram[16'h0890] = 16'hbeef;
    foreach (ram[k]) begin
      acc(PDSAU_OP_DRD, 16'(k), 16'h0, 16'h0, 1'b0, 6'h30);
      chk(x_rdata_out, ram[k]);
      acc(PDSAU_OP_DRD, 16'(k) | 16'h1, 16'h0, 16'h0, 1'b1, 6'h30);
      chk(x_rdata_out, ram[k] >> 8);
    end
    acc(PDSAU_OP_DRD, 16'h0900, 16'h0, 16'h0, 1'b0, 6'h30);
    chk(x_rdata_out, 24'h0);
    for (int j = 0; j < 16; j++) begin
      a = j[2] ? 16'h0890 : 16'h0810;
      d = j[3] ? 16'h0810 : 16'h0890;
      acc(PDSAU_OP_MACRD, a, d, 16'h0, 1'b0, {j[1:0], 4'h0});
      chk(x_rdata_out, (j[1] && a < PDSAU_Y_BASE) ? ram[a] : 16'h0);
      chk(y_rdata_out, (j[0] && d >= PDSAU_Y_BASE) ? ram[d] : 16'h0);
    end
    for (int i = 0; i < 6; i++) begin
      a = 16'h9a40 | 16'(i % 3 == 2);
      e = {8'h85, a[15:1], 1'b0};
      w = pw(e);
      acc(i < 3 ? PDSAU_OP_TRDL : PDSAU_OP_TRDH, a, 16'h0, 16'h0, i % 3 != 0, 6'h30);
      chk(24'(n), 24'h2);
      chk(pa_seen, e);
      if (i < 3) chk(x_rdata_out, i == 0 ? w[15:0] : i == 1 ? w[7:0] : w[15:8]);
      else chk(x_rdata_out, i == 3 ? w[23:16] : i == 4 ? w[23:16] : 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      a = 16'h8000 | 16'(2 * $urandom_range(0, 16383));
      e = {1'b0, 8'h37, a[14:0]};
      cost = i[1] ? (i[0] ? 2 : 1) : (i[2] ? 1 : 2);
      acc(PDSAU_OP_DRD, a, 16'h0, 16'h0, 1'b0, {3'b110, i[2:0]});
      nmap++;
      chk(pa_seen, e);
      chk(x_rdata_out, pw(e) & 24'h00ffff);
      chk(24'(n), 24'(1 + cost));
    end
    reg_rd(PDSAU_REG_STATUS, d);
    chk(d, 24'(nmap));
    for (int i = 0; i < 2; i++) begin
      wd = 16'($urandom());
      acc(i ? PDSAU_OP_TWRH : PDSAU_OP_TWRL, 16'h0420, 16'h0, wd, 1'b0, 6'h30);
      chk(24'(n), 24'h1);
      chk(pmem_addr_out, 24'h850420);
      @(posedge clk_in);
      #1 chk(fl_seen, {1'(i), 7'h00, wd});
    end
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    reg_rd(PDSAU_REG_STATUS, d);
    chk(d, 24'h0);
    chk(x_rdata_out, 24'h0);
    stop_test();
  end
endmodule
`default_nettype wire
